// ==== verilog/ascm_master.sv ====
// Active serial configuration master with bus registers and flash link
//
// What this block does
// - Support one-bit and four-bit data widths
// - Request low, enable high: reset, release pins
// - Oscillator rates 12.5/25/50/100 MHz, never above
// - Start slowest oscillator; option word picks clock
// - Own interface, read stream, hand words onward
// - Start one-bit; option word may select four-bit
// - Drive on falling edge, sample next falling
// - Flash select low throughout the read
// - Shift command and address out serially
// - Chain allowed only in one-bit mode
// - Chain never runs at 100 MHz
// - Shared status: error pulls low, halts chain
// - First device masters; others run passive
// - Finished device drives chain enable low
// - Next device takes data within one clock
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "ascm_defs.svh"

module ascm_master #(
    parameter logic [2:0] SCHEME_AS = 3'h2  // Strap code of master scheme
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        link_clk,
    input  wire logic        config_request_n,
    input  wire logic        chip_enable_in_n,
    input  wire logic [2:0]  scheme_select,
    input  wire logic        user_clock_in,
    output logic             config_clock,
    output logic             config_clock_oe_n,
    output logic             flash_select_out_n,
    output logic             flash_select_oe_n,
    output logic             serial_cmd_out,
    output logic             serial_cmd_oe_n,
    input  wire logic [3:0]  serial_data_in,
    input  wire logic        config_status_n_in,
    output logic             config_status_n_out,
    output logic             config_status_n_oe_n,
    input  wire logic        config_done_flag_in,
    output logic             config_done_flag_out,
    output logic             config_done_flag_oe_n,
    output logic             chip_enable_out_n,
    output logic [31:0]      cfg_word,
    output logic             cfg_word_valid
);

    ascm_pkg::ascm_link_t l;       // Link domain state
    ascm_pkg::ascm_link_t next_l;  // Link domain next state
    ascm_pkg::ascm_host_t h;       // Bus domain state
    ascm_pkg::ascm_host_t next_h;  // Bus domain next state

    // Half period in source cycles for each oscillator setting
    function automatic logic [7:0] half_cnt(input logic [1:0] sel);
        logic [7:0] v;
        v = 8'(`ASCM_HALF(`ASCM_F0_KHZ));
        unique case (sel)
            2'h0: v = 8'(`ASCM_HALF(`ASCM_F0_KHZ));
            2'h1: v = 8'(`ASCM_HALF(`ASCM_F1_KHZ));
            2'h2: v = 8'(`ASCM_HALF(`ASCM_F2_KHZ));
            2'h3: v = 8'(`ASCM_HALF(`ASCM_F3_KHZ));
        endcase
        return v;
    endfunction

    // ---------------------------------------------------------------
    // Link domain: clock generation, command shifting, data sampling
    // ---------------------------------------------------------------
    logic link_rstn;  // Link reset, released on link clock
    assign link_rstn = l.rst_s[1];

    // Link next-state logic
    always_comb begin
        logic        req_lvl;
        logic        req_rise;
        logic        start_ev;
        logic        acked;
        logic        master;
        logic        tick;
        logic        fall;
        logic        run;
        logic [5:0]  inc;
        logic [31:0] nw;
        logic [1:0]  osel;
        req_lvl  = 1'b0;
        req_rise = 1'b0;
        start_ev = 1'b0;
        acked    = 1'b0;
        master   = 1'b0;
        tick     = 1'b0;
        fall     = 1'b0;
        run      = 1'b0;
        inc      = 6'd1;
        nw       = 32'h0;
        osel     = 2'h0;
        next_l   = l;
        next_l.rst_s   = {l.rst_s[0], 1'b1};
        // Three-stage pin and crossing synchronisers
        next_l.req_s   = {l.req_s[1:0], config_request_n};
        next_l.cen_s   = {l.cen_s[1:0], chip_enable_in_n};
        next_l.ucl_s   = {l.ucl_s[1:0], user_clock_in};
        next_l.sts_s   = {l.sts_s[1:0], config_status_n_in};
        next_l.start_s = {l.start_s[1:0], h.start_tog};
        next_l.ack_s   = {l.ack_s[1:0], h.ack_tog};
        next_l.sch_s   = {l.sch_s[1:0], scheme_select};
        next_l.bnd1    = h.bnd;
        next_l.bnd2    = l.bnd1;
        next_l.bnd3    = l.bnd2;
        // A request rise and an acknowledge count once the second and third stages agree; a start counts when they differ
        req_lvl  = l.req_s[2];
        req_rise = l.req_s[1] & l.req_s[2];  // Idle is entered only at reset or with request low
        start_ev = l.start_s[1] ^ l.start_s[2];
        acked    = (l.ack_s[1] == l.ack_s[2]) && (l.ack_s[2] == l.req_tog);
        master   = (l.sch_s[2] == SCHEME_AS);
        inc      = l.quad ? 6'd4 : 6'd1;
        run      = (l.st == ascm_pkg::L_CMD) || (l.st == ascm_pkg::L_DATA);

        // Clock tick from oscillator divider or the user clock pin
        if (l.user_clk) begin
            tick = l.ucl_s[1] ^ l.ucl_s[2];
        end else begin
            tick = (l.div == 8'h0);
        end
        if (run) begin
            if (l.div == 8'h0) begin
                next_l.div = 8'(half_cnt(l.clk_sel) - 8'h1);
            end else begin
                next_l.div = 8'(l.div - 8'h1);
            end
            if (tick) begin
                next_l.cclk = ~l.cclk;
            end
        end else begin
            next_l.div = 8'(half_cnt(l.clk_sel) - 8'h1);
        end
        fall = run & tick & l.cclk;
        nw   = l.quad ? {l.word[27:0], serial_data_in} :
                        {l.word[30:0], serial_data_in[0]};

        unique case (l.st)
            // Waiting for a start from software or request release
            ascm_pkg::L_IDLE: begin
                next_l.cclk  = 1'b1;
                next_l.sel_n = 1'b1;
                if (master && req_lvl && (start_ev || req_rise)) begin
                    next_l.st = ascm_pkg::L_ARM;
                end
            end
            // One cycle lets the settings bundle settle after the toggle
            ascm_pkg::L_ARM: begin
                next_l.addr     = l.bnd3.addr;
                next_l.len      = l.bnd3.len;
                next_l.chain    = l.bnd3.chain;
                next_l.comp     = l.bnd3.comp;
                next_l.shreg    = {`ASCM_CMD_READ, l.bnd3.addr};
                next_l.bitcnt   = 6'd0;
                next_l.quad     = 1'b0;
                next_l.clk_sel  = 2'h0;
                next_l.div      = 8'(half_cnt(2'h0) - 8'h1);
                next_l.user_clk = 1'b0;
                next_l.first    = 1'b1;
                next_l.wcnt     = 16'h0;
                next_l.dcnt     = 6'd0;
                next_l.sel_n    = 1'b0;
                next_l.st       = ascm_pkg::L_CMD;
            end
            // Command and address, one bit per falling edge
            ascm_pkg::L_CMD: begin
                if (fall) begin
                    if (l.bitcnt == `ASCM_CMD_BITS) begin
                        next_l.st = ascm_pkg::L_DATA;
                    end else begin
                        next_l.cmd_o  = l.shreg[31];
                        next_l.shreg  = {l.shreg[30:0], 1'b0};
                        next_l.bitcnt = 6'(l.bitcnt + 6'd1);
                    end
                end
            end
            // Stream sampling, one or four bits per falling edge
            ascm_pkg::L_DATA: begin
                if (fall) begin
                    next_l.word = nw;
                    if (6'(l.dcnt + inc) == `ASCM_WORD_BITS) begin
                        next_l.dcnt      = 6'd0;
                        next_l.hold_word = nw;
                        next_l.req_tog   = ~l.req_tog;
                        next_l.wcnt      = 16'(l.wcnt + 16'h1);
                        next_l.st        = ascm_pkg::L_WAIT;
                        if (l.first) begin
                            // Option word sets clock and width
                            next_l.first = 1'b0;
                            osel = nw[`ASCM_OPT_CLK_LO +: 2];
                            if (l.chain && (osel == 2'h3)) begin
                                osel = 2'h2;
                            end
                            next_l.clk_sel  = osel;
                            next_l.user_clk = nw[`ASCM_OPT_USER];
                            next_l.quad = nw[`ASCM_OPT_QUAD]
                                        & ~l.chain;
                            if (l.chain && nw[`ASCM_OPT_QUAD]) begin
                                next_l.st = ascm_pkg::L_ERR;
                            end
                        end
                    end else begin
                        next_l.dcnt = 6'(l.dcnt + inc);
                    end
                end
            end
            // Clock paused until the bus side has taken the word
            ascm_pkg::L_WAIT: begin
                if (acked) begin
                    if (l.wcnt == l.len) begin
                        next_l.st = ascm_pkg::L_DONE;
                    end else begin
                        next_l.st = ascm_pkg::L_DATA;
                    end
                end
            end
            // Finished or halted: flash released until a new request
            ascm_pkg::L_DONE, ascm_pkg::L_ERR: begin
                next_l.cclk  = 1'b1;
                next_l.sel_n = 1'b1;
            end
        endcase
        // Another device pulling status low halts this one too
        if ((run || l.st == ascm_pkg::L_WAIT) && !l.sts_s[2]
            && l.sts_s[1] == l.sts_s[2]) begin
            next_l.st = ascm_pkg::L_ERR;
        end
        // Request held low restarts the whole sequence
        if (!req_lvl) begin
            next_l.st    = ascm_pkg::L_IDLE;
            next_l.cclk  = 1'b1;
            next_l.sel_n = 1'b1;
        end

        // Pin drivers; released when not master or when taken over
        next_l.pin_oe_n = !master || (!req_lvl && l.cen_s[2]);
        next_l.sts_oe_n = !(next_l.st == ascm_pkg::L_ERR);
        next_l.done_oe_n = !master
                         || (next_l.st == ascm_pkg::L_DONE);
        next_l.ceo_n = !(master && l.st == ascm_pkg::L_DONE
                         && next_l.st == ascm_pkg::L_DONE);
    end

    // Link registers; reset release is synchronised to the link clock
    always_ff @(posedge link_clk or negedge hresetn) begin
        if (!hresetn) begin
            l          <= '0;
            l.st       <= ascm_pkg::L_IDLE;
            l.cclk     <= 1'b1;
            l.sel_n    <= 1'b1;
            l.pin_oe_n <= 1'b1;
            l.sts_oe_n <= 1'b1;
            l.done_oe_n <= 1'b1;
            l.ceo_n    <= 1'b1;
        end else if (!link_rstn) begin
            l.rst_s <= {l.rst_s[0], 1'b1};
        end else begin
            l <= next_l;
        end
    end

    // Link pins
    assign config_clock          = l.cclk;
    assign config_clock_oe_n     = l.pin_oe_n;
    assign flash_select_out_n    = l.sel_n;
    assign flash_select_oe_n     = l.pin_oe_n;
    assign serial_cmd_out        = l.cmd_o;
    assign serial_cmd_oe_n       = l.pin_oe_n;
    assign config_status_n_out   = 1'b0;
    assign config_status_n_oe_n  = l.sts_oe_n;
    assign config_done_flag_out  = 1'b0;
    assign config_done_flag_oe_n = l.done_oe_n;
    assign chip_enable_out_n     = l.ceo_n;

    // Flags that the bus side reads, decoded from link flops
    ascm_pkg::ascm_flags_t link_flags;
    assign link_flags.busy = !(l.st inside {ascm_pkg::L_IDLE,
                               ascm_pkg::L_DONE, ascm_pkg::L_ERR});
    assign link_flags.done = (l.st == ascm_pkg::L_DONE);
    assign link_flags.err  = (l.st == ascm_pkg::L_ERR);
    assign link_flags.quad = l.quad;

    // ---------------------------------------------------------------
    // Bus domain: AHB-Lite slave, settings, word capture
    // ---------------------------------------------------------------

    // Bus next-state logic
    always_comb begin
        logic        wev;
        logic        rd_data;
        logic [31:0] st_word;
        wev      = 1'b0;
        rd_data  = 1'b0;
        st_word  = 32'h0;
        next_h   = h;
        next_h.wreq_s = {h.wreq_s[1:0], l.req_tog};
        next_h.flg_s  = {h.flg_s[1:0], link_flags};
        next_h.don_s  = {h.don_s[1:0], config_done_flag_in};
        next_h.cfg_word_valid = 1'b0;
        wev = h.wreq_s[1] ^ h.wreq_s[2];

        // Status word from synchronised link flags
        st_word[`ASCM_ST_BUSY]  = h.flg_s[2][3];
        st_word[`ASCM_ST_DONE]  = h.flg_s[2][2];
        st_word[`ASCM_ST_ERR]   = h.flg_s[2][1];
        st_word[`ASCM_ST_QUAD]  = h.flg_s[2][0];
        st_word[`ASCM_ST_USER]  = h.flg_s[2][2] & h.don_s[2];
        st_word[`ASCM_ST_VALID] = h.valid;

        // Address phase; read data is prepared for the data phase
        next_h.wr = 1'b0;
        if (hsel && hready && htrans[1]) begin
            next_h.wr = hwrite;
            next_h.wa = haddr[7:0];
            if (!hwrite) begin
                unique case (haddr[7:0])
                    `ASCM_OFF_CTRL: begin
                        next_h.hrdata = {29'h0, h.bnd.comp, h.bnd.chain, 1'b0};
                    end
                    `ASCM_OFF_ADDR:   next_h.hrdata = {8'h0, h.bnd.addr};
                    `ASCM_OFF_LEN:    next_h.hrdata = {16'h0, h.bnd.len};
                    `ASCM_OFF_STATUS: next_h.hrdata = st_word;
                    `ASCM_OFF_DATA: begin
                        next_h.hrdata = h.data;
                        rd_data = 1'b1;
                    end
                    default:          next_h.hrdata = 32'h0;
                endcase
            end
        end

        // Data phase of a write
        if (h.wr) begin
            unique case (h.wa)
                `ASCM_OFF_CTRL: begin
                    next_h.bnd.chain = hwdata[`ASCM_CTRL_CHAIN];
                    next_h.bnd.comp  = hwdata[`ASCM_CTRL_COMP];
                    if (hwdata[`ASCM_CTRL_START]) begin
                        next_h.start_tog = ~h.start_tog;
                    end
                end
                `ASCM_OFF_ADDR: next_h.bnd.addr = hwdata[23:0];
                `ASCM_OFF_LEN:  next_h.bnd.len  = hwdata[15:0];
                default: begin
                end
            endcase
        end

        // Reading the data register clears the flag; a new word wins
        if (rd_data) begin
            next_h.valid = 1'b0;
        end
        if (wev) begin
            next_h.data           = l.hold_word;
            next_h.cfg_word       = l.hold_word;
            next_h.cfg_word_valid = 1'b1;
            next_h.valid          = 1'b1;
            next_h.ack_tog        = h.wreq_s[1];
        end
    end

    // Bus registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            h          <= '0;
            h.bnd.addr <= `ASCM_RST_ADDR;
            h.bnd.len  <= `ASCM_RST_LEN;
        end else begin
            h <= next_h;
        end
    end

    // Slave answers with no wait states and always OKAY
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign hrdata         = h.hrdata;
    assign cfg_word       = h.cfg_word;
    assign cfg_word_valid = h.cfg_word_valid;

endmodule

// ==== common/ascm_defs.svh ====
// Offsets, field positions, reset values and timing counts of the loader
`ifndef ASCM_DEFS_SVH
`define ASCM_DEFS_SVH

// Register byte offsets
`define ASCM_OFF_CTRL     8'h00
`define ASCM_OFF_ADDR     8'h04
`define ASCM_OFF_LEN      8'h08
`define ASCM_OFF_STATUS   8'h0c
`define ASCM_OFF_DATA     8'h10

// Control register fields
`define ASCM_CTRL_START   0
`define ASCM_CTRL_CHAIN   1
`define ASCM_CTRL_COMP    2

// Status register fields
`define ASCM_ST_BUSY      0
`define ASCM_ST_DONE      1
`define ASCM_ST_ERR       2
`define ASCM_ST_QUAD      3
`define ASCM_ST_USER      4
`define ASCM_ST_VALID     8

// Reset values
`define ASCM_RST_ADDR     24'h000000
`define ASCM_RST_LEN      16'h0001

// Option word fields, first word read from the flash
`define ASCM_OPT_CLK_LO   0
`define ASCM_OPT_QUAD     2
`define ASCM_OPT_USER     3

// Flash read command and frame sizes
`define ASCM_CMD_READ     8'h03
`define ASCM_CMD_BITS     6'd32
`define ASCM_WORD_BITS    6'd32

// Clock source and nominal configuration clock rates in kHz
`define ASCM_SRC_KHZ      200000
`define ASCM_F0_KHZ       12500
`define ASCM_F1_KHZ       25000
`define ASCM_F2_KHZ       50000
`define ASCM_F3_KHZ       100000
`define ASCM_HALF(f)      (`ASCM_SRC_KHZ / (2 * (f)))

`endif

// ==== common/ascm_pkg.sv ====
// Types shared by the active serial configuration master
package ascm_pkg;

    // Link side sequencer states
    typedef enum logic [2:0] {
        L_IDLE,
        L_ARM,
        L_CMD,
        L_DATA,
        L_WAIT,
        L_DONE,
        L_ERR
    } ascm_link_state_t;

    // Settings handed from the bus side to the link side
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] len;
        logic        chain;
        logic        comp;
    } ascm_bundle_t;

    // Progress flags handed from the link side to the bus side
    typedef struct packed {
        logic busy;
        logic done;
        logic err;
        logic quad;
    } ascm_flags_t;

    // All state of the link domain
    typedef struct packed {
        logic [1:0]       rst_s;
        ascm_link_state_t st;
        logic [2:0]       req_s;
        logic [2:0]       cen_s;
        logic [2:0]       ucl_s;
        logic [2:0]       sts_s;
        logic [2:0]       start_s;
        logic [2:0]       ack_s;
        logic [2:0][2:0]  sch_s;
        ascm_bundle_t     bnd1;
        ascm_bundle_t     bnd2;
        ascm_bundle_t     bnd3;
        logic [23:0]      addr;
        logic [15:0]      len;
        logic             chain;
        logic             comp;
        logic [7:0]       div;
        logic [1:0]       clk_sel;
        logic             user_clk;
        logic             quad;
        logic             first;
        logic [31:0]      shreg;
        logic [5:0]       bitcnt;
        logic [31:0]      word;
        logic [5:0]       dcnt;
        logic [15:0]      wcnt;
        logic [31:0]      hold_word;
        logic             req_tog;
        logic             cclk;
        logic             sel_n;
        logic             cmd_o;
        logic             pin_oe_n;
        logic             sts_oe_n;
        logic             done_oe_n;
        logic             ceo_n;
    } ascm_link_t;

    // All state of the bus domain
    typedef struct packed {
        logic             wr;
        logic [7:0]       wa;
        logic [31:0]      hrdata;
        ascm_bundle_t     bnd;
        logic             start_tog;
        logic             ack_tog;
        logic [2:0]       wreq_s;
        logic [2:0][3:0]  flg_s;
        logic [2:0]       don_s;
        logic [31:0]      data;
        logic             valid;
        logic [31:0]      cfg_word;
        logic             cfg_word_valid;
    } ascm_host_t;

endpackage

// ==== test/ascm_master_monitor.sv ====
// Assertion checker for the configuration master pins
`timescale 1ns/1ps
module ascm_master_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic link_clk,
    input wire logic config_request_n,
    input wire logic chip_enable_in_n,
    input wire logic config_clock,
    input wire logic config_clock_oe_n,
    input wire logic flash_select_out_n,
    input wire logic flash_select_oe_n,
    input wire logic serial_cmd_out,
    input wire logic serial_cmd_oe_n,
    input wire logic config_status_n_out,
    input wire logic config_status_n_oe_n,
    input wire logic chip_enable_out_n,
    input wire logic cfg_word_valid
);
    // A read access opens when select falls
    sequence s_open;
        $fell(flash_select_out_n);
    endsequence
    // Chain handover starts when enable out falls
    sequence s_hand;
        $fell(chip_enable_out_n);
    endsequence
    a_req_deselect: assert property (@(posedge link_clk) disable iff (!hresetn)
        !config_request_n |-> ##[1:8] flash_select_out_n)
        else $error("select not raised on request");
    a_release_pins: assert property (@(posedge link_clk) disable iff (!hresetn)
        !config_request_n && chip_enable_in_n |-> ##[1:8]
        (flash_select_oe_n && serial_cmd_oe_n && config_clock_oe_n))
        else $error("pins not released");
    a_start_slow: assert property (@(posedge link_clk) disable iff (!hresetn)
        s_open |-> config_clock [*7])
        else $error("clock not slowest at start");
    a_cmd_on_fall: assert property (@(posedge link_clk) disable iff (!hresetn)
        !flash_select_out_n && !$past(flash_select_out_n)
        && $changed(serial_cmd_out) |-> $fell(config_clock))
        else $error("command bit moved off a falling edge");
    a_done_idle: assert property (@(posedge link_clk) disable iff (!hresetn)
        s_hand |-> flash_select_out_n && config_clock)
        else $error("handover while flash selected");
    a_idle_clock: assert property (@(posedge link_clk) disable iff (!hresetn)
        flash_select_out_n && $past(flash_select_out_n)
        && config_status_n_oe_n |-> config_clock)
        else $error("clock not idle while deselected");
    a_err_pull: assert property (@(posedge link_clk) disable iff (!hresetn)
        !config_status_n_oe_n |-> !config_status_n_out && chip_enable_out_n)
        else $error("status not pulled low on error");
    a_word_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg_word_valid |=> !cfg_word_valid)
        else $error("word strobe longer than one cycle");
endmodule
bind ascm_master ascm_master_monitor u_mon (.*);

// ==== test/ascm_flash_model.sv ====
// Behavioural serial flash answering the read command
`timescale 1ns/1ps
module ascm_flash_model (
    input  wire logic        config_clock,
    input  wire logic        flash_chip_select_n,
    input  wire logic        serial_cmd_out,
    input  wire logic [31:0] opt,
    output logic [3:0]       serial_data_in,
    output logic [31:0]      got_cmd
);
    int          rc, bc, wi; // Rising edges, bits in word, word index
    logic        q;          // Quad width in force
    logic [31:0] sh;         // Word being sent
    initial begin
        serial_data_in = 4'h0;
        got_cmd = 32'h0;
        rc = 0;
    end
    // Deselected: show the inverse so stale data never looks valid
    always @(posedge flash_chip_select_n) begin
        rc = 0;
        bc = 0;
        wi = 0;
        serial_data_in <= ~serial_data_in;
    end
    // Command and address taken on rising edges
    always @(posedge config_clock) if (!flash_chip_select_n && rc < 32) begin
        got_cmd = {got_cmd[30:0], serial_cmd_out};
        rc++;
    end
    // Data on falling edges, option word first, bit 3 first in quad
    always @(negedge config_clock) if (!flash_chip_select_n && rc == 32) begin
        q = wi > 0 && opt[2];
        if (bc == 0) sh = (wi == 0) ? opt : 32'hc0de0000 + 32'(wi);
        serial_data_in <= q ? sh[31:28] : {~serial_data_in[3:1], sh[31]};
        sh = q ? sh << 4 : sh << 1;
        bc = bc + (q ? 4 : 1);
        if (bc == 32) begin
            bc = 0;
            wi++;
        end
    end
endmodule

// ==== test/active_serial_config_master_tb_top.sv ====
// Self-checking bench for the configuration master
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module active_serial_config_master_tb_top;
    logic        hclk, hresetn, link_clk, hsel, hwrite, hready, hreadyout;
    logic        hresp, config_request_n, chip_enable_in_n, user_clock_in;
    logic        config_clock, config_clock_oe_n, flash_select_out_n;
    logic        flash_select_oe_n, serial_cmd_out, serial_cmd_oe_n;
    logic        config_status_n_in, config_status_n_out, config_status_n_oe_n;
    logic        config_done_flag_in, config_done_flag_out;
    logic        config_done_flag_oe_n, chip_enable_out_n, cfg_word_valid;
    logic [1:0]  htrans;
    logic [2:0]  hsize, scheme_select;
    logic [3:0]  serial_data_in;
    logic [31:0] haddr, hwdata, hrdata, cfg_word, opt, got_cmd, rd;
    logic [31:0] got [8];
    int          n, err_total, compares;
    // Open-drain lines with pull-ups
    assign config_status_n_in = config_status_n_oe_n | config_status_n_out;
    assign config_done_flag_in = config_done_flag_oe_n | config_done_flag_out;
    ascm_master dut (.*);
    assign hready = hreadyout;
    ascm_flash_model u_flash (.config_clock, .flash_chip_select_n(flash_select_out_n),
        .serial_cmd_out, .opt, .serial_data_in, .got_cmd);
    initial begin hclk = 0; forever #5 hclk = ~hclk; end
    initial begin link_clk = 0; #7; forever #15 link_clk = ~link_clk; end
    initial begin user_clock_in = 0; forever #6 user_clock_in = ~user_clock_in; end
    // Words as the bus side hands them on
    always @(posedge hclk) if (cfg_word_valid === 1'b1 && n < 8) begin
        got[n] = cfg_word;
        n++;
    end
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One single word transfer; waits on ready under a bound
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 64);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 128);
        rd = hrdata;
        if (k >= 128) begin err_total++; report_and_stop; end
    endtask
    // Set up, raise request, wait for done or error
    task automatic load(input logic [31:0] o, input logic [31:0] ctl);
        int k;
        k = 0;
        opt = o; n = 0;
        bus(1, 8'h04, 32'h00123456);
        bus(1, 8'h08, 32'h3);
        bus(1, 8'h00, ctl);
        config_request_n <= 1'b1;
        do bus(0, 8'h0c, 0); while (rd[2:1] === 2'b00 && ++k < 8000);
        if (k >= 8000) begin err_total++; report_and_stop; end
        repeat (10) @(posedge hclk);
    endtask
    // Full read: command, option word, two data words, handover
    task automatic t_read(input logic [31:0] o, input logic [3:0] st);
        load(o, 32'h0);
        `CHK(rd[3:0], st)
        `CHK(got_cmd, 32'h03123456)
        `CHK(n, 3)
        for (int i = 0; i < 3; i++) `CHK(got[i], i ? 32'hc0de0000 + i : o)
        `CHK({chip_enable_out_n, flash_select_out_n}, 2'b01)
        config_request_n <= 1'b0;
        repeat (20) @(posedge hclk);
        `CHK({flash_select_out_n, config_clock}, 2'b11)
        $display("read with option %h finished", o);
    endtask
    initial begin
        hresetn = 0; hsel = 0; hwrite = 0; htrans = 0; hsize = 3'h2;
        haddr = 0; hwdata = 0; config_request_n = 0; chip_enable_in_n = 0;
        scheme_select = 3'h2; opt = 0; n = 0;
        err_total = 0; compares = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values and an unmapped place
        bus(0, 8'h00, 0); `CHK(rd, 32'h0)
        bus(0, 8'h04, 0); `CHK(rd, 32'h0)
        bus(0, 8'h08, 0); `CHK(rd, 32'h1)
        bus(0, 8'h20, 0); `CHK(rd, 32'h0)
        `CHK({flash_select_out_n, config_clock}, 2'b11)
        $display("reset values finished");
        t_read(32'h0, 4'b0010);
        t_read(32'h6, 4'b1010);
        t_read(32'h8, 4'b0010);
        // Quad option in a chain halts with status pulled low
        load(32'h4, 32'h2);
        `CHK({rd[2], config_status_n_oe_n}, 2'b10)
        chip_enable_in_n <= 1'b1;
        config_request_n <= 1'b0;
        repeat (20) @(posedge hclk);
        `CHK({flash_select_oe_n, serial_cmd_oe_n, config_clock_oe_n}, 3'h7)
        $display("chain quad refusal finished");
        report_and_stop;
    end
    initial begin
        #1ms;
        err_total++;
        report_and_stop;
    end
endmodule
